// ---- logic/trf_defs.svh ----
// register offsets, field positions, reset values and timing figures of the result path
`ifndef TRF_DEFS_SVH
`define TRF_DEFS_SVH

`define TRF_ADDR_CFG1 8'h01
`define TRF_ADDR_CFG2 8'h02
`define TRF_ADDR_LOC_HIGH 8'h0b
`define TRF_ADDR_LOC_LOW 8'h0c
`define TRF_ADDR_LOC_OVT 8'h0d
`define TRF_ADDR_REM_HIGH 8'h0e
`define TRF_ADDR_REM_LOW 8'h0f
`define TRF_ADDR_REM_OVT 8'h10
`define TRF_ADDR_LOC_OFS 8'h16
`define TRF_ADDR_REM_OFS 8'h17
`define TRF_ADDR_LOC_FRAC 8'h40
`define TRF_ADDR_LOC_INT 8'h41
`define TRF_ADDR_REM_FRAC 8'h42
`define TRF_ADDR_REM_INT 8'h43

`define TRF_CFG1_MONITOR_BIT 0
`define TRF_CFG1_AVG_DIS_BIT 1
`define TRF_CFG2_CYCLE_BIT 7
`define TRF_CFG2_SEL_HI 5
`define TRF_CFG2_SEL_LO 4

`define TRF_RST_CFG1 8'h01
`define TRF_RST_CFG2 8'h80
`define TRF_RST_HIGH 8'h8b
`define TRF_RST_LOW 8'h54
`define TRF_RST_OVT 8'h95
`define TRF_RST_OFS 8'h00
`define TRF_RST_RESULT 8'h00

`define TRF_SEL_LOCAL 2'h0
`define TRF_SEL_REMOTE 2'h1
`define TRF_AVG_COUNT 16
`define TRF_CLK_HZ 25000000
`define TRF_LOCAL_MS 11
`define TRF_REMOTE_AVG_MS 32
`define TRF_REMOTE_RAW_MS 6

`endif

// ---- logic/trf_pkg.sv ----
// types shared by the temperature result path
package trf_pkg;

  // conversion slot, one-hot
  typedef enum logic [2:0]
  {
    TRF_IDLE = 3'h1,
    TRF_LOCAL = 3'h2,
    TRF_REMOTE = 3'h4
  } trf_slot_t;

endpackage

// ---- logic/trf_result_path.sv ----
// temperature result formatting, averaging, offset, limits and register port
`timescale 1ns/1ps
`include "trf_defs.svh"

// Behaviour
// RQ1 - result is 13 bits over two registers
// RQ2 - integer byte is offset-64, one degree steps
// RQ3 - five fraction bits, each 1/32 degree
// RQ4 - span is -64 to +191.96875 degrees
// RQ5 - slow rates average sixteen measurements
// RQ6 - fast rates store single measurements
// RQ7 - config1 bit 1 disables averaging
// RQ8 - remote slot 32 ms averaged, 6 ms not
// RQ9 - config2 bit 7 cycles all channels
// RQ10 - config2 bits 5:4 pick single channel
// RQ11 - results at 0x40..0x43, reset zero
// RQ12 - beyond limit sets flag, may alert
// RQ13 - high, low, overtemp limits with defaults
// RQ14 - per-channel offset added before storing
// RQ15 - offset is signed, 0.125 degree step
// RQ16 - fraction read freezes channel until integer read
// RQ17 - high flags at or above, low below
// RQ18 - compare corrected integer byte with limits
module trf_result_path #(
  parameter int CNT_W = 20,
  parameter int LOCAL_CYC = `TRF_LOCAL_MS * (`TRF_CLK_HZ / 1000),
  parameter int REMOTE_AVG_CYC = `TRF_REMOTE_AVG_MS * (`TRF_CLK_HZ / 1000),
  parameter int REMOTE_RAW_CYC = `TRF_REMOTE_RAW_MS * (`TRF_CLK_HZ / 1000)
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic rate_fast,
  input wire logic meas_valid,
  input wire logic [12:0] meas_data,
  output logic meas_start,
  output logic meas_remote,
  output logic loc_high_flag,
  output logic loc_low_flag,
  output logic loc_overtemp_flag,
  output logic rem_high_flag,
  output logic rem_low_flag,
  output logic rem_overtemp_flag,
  output logic alert_n
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // add signed offset (1/8 degree steps = 4 result lsbs), clamp to 13-bit span
  function automatic logic [12:0] trf_apply_offset(input logic [12:0] v, input logic [7:0] ofs);
    logic signed [15:0] sum;
    sum = signed'({3'h0, v}) + signed'({{6{ofs[7]}}, ofs, 2'h0}); // RQ14 RQ15
    if (sum < 16'sh0000)
      trf_apply_offset = 13'h0000; // RQ4
    else if (sum > 16'sh1fff)
      trf_apply_offset = 13'h1fff; // RQ4
    else
      trf_apply_offset = sum[12:0];
  endfunction

  // limit check on the integer byte: {high, low, overtemp}
  function automatic logic [2:0] trf_limits(input logic [12:0] v, input logic [7:0] hi,
    input logic [7:0] lo, input logic [7:0] ovt);
    trf_limits[2] = v[12:5] >= hi; // RQ17 RQ18
    trf_limits[1] = v[12:5] < lo; // RQ17 RQ18
    trf_limits[0] = v[12:5] >= ovt; // RQ18
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register file

  logic [7:0] cfg1_r, cfg1_nxt;
  logic [7:0] cfg2_r, cfg2_nxt;
  logic [7:0] loc_high_r, loc_high_nxt, loc_low_r, loc_low_nxt, loc_ovt_r, loc_ovt_nxt;
  logic [7:0] rem_high_r, rem_high_nxt, rem_low_r, rem_low_nxt, rem_ovt_r, rem_ovt_nxt;
  logic [7:0] loc_ofs_r, loc_ofs_nxt, rem_ofs_r, rem_ofs_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [12:0] loc_res_r, rem_res_r;

  // writes to read-only or unmapped offsets are dropped
  always_comb
  begin
    cfg1_nxt = cfg1_r;
    cfg2_nxt = cfg2_r;
    loc_high_nxt = loc_high_r;
    loc_low_nxt = loc_low_r;
    loc_ovt_nxt = loc_ovt_r;
    rem_high_nxt = rem_high_r;
    rem_low_nxt = rem_low_r;
    rem_ovt_nxt = rem_ovt_r;
    loc_ofs_nxt = loc_ofs_r;
    rem_ofs_nxt = rem_ofs_r;
    if (reg_wr)
    begin
      unique case (reg_addr)
        `TRF_ADDR_CFG1: cfg1_nxt = reg_wdata;
        `TRF_ADDR_CFG2: cfg2_nxt = reg_wdata;
        `TRF_ADDR_LOC_HIGH: loc_high_nxt = reg_wdata; // RQ13
        `TRF_ADDR_LOC_LOW: loc_low_nxt = reg_wdata; // RQ13
        `TRF_ADDR_LOC_OVT: loc_ovt_nxt = reg_wdata; // RQ13
        `TRF_ADDR_REM_HIGH: rem_high_nxt = reg_wdata; // RQ13
        `TRF_ADDR_REM_LOW: rem_low_nxt = reg_wdata; // RQ13
        `TRF_ADDR_REM_OVT: rem_ovt_nxt = reg_wdata; // RQ13
        `TRF_ADDR_LOC_OFS: loc_ofs_nxt = reg_wdata; // RQ14
        `TRF_ADDR_REM_OFS: rem_ofs_nxt = reg_wdata; // RQ14
        default: ;
      endcase
    end
    // read data is held between reads; unmapped reads give zero
    rdata_nxt = rdata_r;
    if (reg_rd)
    begin
      unique case (reg_addr)
        `TRF_ADDR_CFG1: rdata_nxt = cfg1_r;
        `TRF_ADDR_CFG2: rdata_nxt = cfg2_r;
        `TRF_ADDR_LOC_HIGH: rdata_nxt = loc_high_r;
        `TRF_ADDR_LOC_LOW: rdata_nxt = loc_low_r;
        `TRF_ADDR_LOC_OVT: rdata_nxt = loc_ovt_r;
        `TRF_ADDR_REM_HIGH: rdata_nxt = rem_high_r;
        `TRF_ADDR_REM_LOW: rdata_nxt = rem_low_r;
        `TRF_ADDR_REM_OVT: rdata_nxt = rem_ovt_r;
        `TRF_ADDR_LOC_OFS: rdata_nxt = loc_ofs_r;
        `TRF_ADDR_REM_OFS: rdata_nxt = rem_ofs_r;
        `TRF_ADDR_LOC_FRAC: rdata_nxt = {3'h0, loc_res_r[4:0]}; // RQ1 RQ3 RQ11
        `TRF_ADDR_LOC_INT: rdata_nxt = loc_res_r[12:5]; // RQ1 RQ2 RQ11
        `TRF_ADDR_REM_FRAC: rdata_nxt = {3'h0, rem_res_r[4:0]}; // RQ1 RQ3 RQ11
        `TRF_ADDR_REM_INT: rdata_nxt = rem_res_r[12:5]; // RQ1 RQ2 RQ11
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cfg1_r <= `TRF_RST_CFG1;
      cfg2_r <= `TRF_RST_CFG2;
      loc_high_r <= `TRF_RST_HIGH;
      loc_low_r <= `TRF_RST_LOW;
      loc_ovt_r <= `TRF_RST_OVT;
      rem_high_r <= `TRF_RST_HIGH;
      rem_low_r <= `TRF_RST_LOW;
      rem_ovt_r <= `TRF_RST_OVT;
      loc_ofs_r <= `TRF_RST_OFS; // RQ15
      rem_ofs_r <= `TRF_RST_OFS; // RQ15
      rdata_r <= 8'h00;
    end
    else if (ce)
    begin
      cfg1_r <= cfg1_nxt;
      cfg2_r <= cfg2_nxt;
      loc_high_r <= loc_high_nxt;
      loc_low_r <= loc_low_nxt;
      loc_ovt_r <= loc_ovt_nxt;
      rem_high_r <= rem_high_nxt;
      rem_low_r <= rem_low_nxt;
      rem_ovt_r <= rem_ovt_nxt;
      loc_ofs_r <= loc_ofs_nxt;
      rem_ofs_r <= rem_ofs_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // conversion sequencer and averaging

  trf_pkg::trf_slot_t slot_r, slot_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [16:0] acc_r, acc_nxt;
  logic [4:0] nsamp_r, nsamp_nxt;
  logic pend_r, pend_nxt, done_r, done_nxt, start_r, start_nxt, chan_r, chan_nxt;
  logic store;
  logic [12:0] store_val;
  logic avg_on, cycle_all, sel_remote, now_remote;
  logic [4:0] need;
  logic [CNT_W-1:0] slot_len;

  assign avg_on = !cfg1_r[`TRF_CFG1_AVG_DIS_BIT] && !rate_fast; // RQ5 RQ6 RQ7
  assign need = avg_on ? 5'(`TRF_AVG_COUNT) : 5'h01; // RQ5 RQ6
  assign cycle_all = cfg2_r[`TRF_CFG2_CYCLE_BIT]; // RQ9
  // reserved selector codes fall back to the local channel
  assign sel_remote = cfg2_r[`TRF_CFG2_SEL_HI:`TRF_CFG2_SEL_LO] == `TRF_SEL_REMOTE; // RQ10
  assign now_remote = slot_r == trf_pkg::TRF_REMOTE;
  assign slot_len = !now_remote ? CNT_W'(LOCAL_CYC)
    : avg_on ? CNT_W'(REMOTE_AVG_CYC) : CNT_W'(REMOTE_RAW_CYC); // RQ8

  // one request to the converter at a time; a late sample after slot end is lost
  always_comb
  begin
    slot_nxt = slot_r;
    cnt_nxt = cnt_r;
    acc_nxt = acc_r;
    nsamp_nxt = nsamp_r;
    pend_nxt = pend_r;
    done_nxt = done_r;
    start_nxt = 1'b0;
    store = 1'b0;
    store_val = 13'h0000;
    unique case (slot_r)
      trf_pkg::TRF_IDLE:
      begin
        if (cfg1_r[`TRF_CFG1_MONITOR_BIT])
        begin
          slot_nxt = (!cycle_all && sel_remote) ? trf_pkg::TRF_REMOTE : trf_pkg::TRF_LOCAL;
          cnt_nxt = '0;
        end
      end
      trf_pkg::TRF_LOCAL, trf_pkg::TRF_REMOTE:
      begin
        cnt_nxt = cnt_r + 1'b1;
        if (meas_valid && pend_r)
        begin
          pend_nxt = 1'b0;
          acc_nxt = acc_r + 17'(meas_data);
          nsamp_nxt = nsamp_r + 1'b1;
          if (nsamp_r + 1'b1 == need)
          begin
            store = 1'b1;
            store_val = avg_on ? acc_nxt[16:4] : meas_data; // RQ5 RQ6
            done_nxt = 1'b1;
          end
        end
        if (!cfg1_r[`TRF_CFG1_MONITOR_BIT])
        begin
          slot_nxt = trf_pkg::TRF_IDLE;
          pend_nxt = 1'b0;
          done_nxt = 1'b0;
          acc_nxt = '0;
          nsamp_nxt = '0;
        end
        else if (cnt_r + 1'b1 >= slot_len)
        begin
          // round robin alternates, single mode stays on the chosen one
          if (cycle_all)
            slot_nxt = now_remote ? trf_pkg::TRF_LOCAL : trf_pkg::TRF_REMOTE; // RQ9
          else
            slot_nxt = sel_remote ? trf_pkg::TRF_REMOTE : trf_pkg::TRF_LOCAL; // RQ10
          cnt_nxt = '0;
          pend_nxt = 1'b0;
          done_nxt = 1'b0;
          acc_nxt = '0;
          nsamp_nxt = '0;
        end
        else if (!pend_nxt && !done_nxt)
        begin
          start_nxt = 1'b1;
          pend_nxt = 1'b1;
        end
      end
    endcase
    // channel is held through the slot so the converter may read it any time
    chan_nxt = slot_nxt == trf_pkg::TRF_REMOTE;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      slot_r <= trf_pkg::TRF_IDLE;
      cnt_r <= '0;
      acc_r <= '0;
      nsamp_r <= '0;
      pend_r <= 1'b0;
      done_r <= 1'b0;
      start_r <= 1'b0;
      chan_r <= 1'b0;
    end
    else if (ce)
    begin
      slot_r <= slot_nxt;
      cnt_r <= cnt_nxt;
      acc_r <= acc_nxt;
      nsamp_r <= nsamp_nxt;
      pend_r <= pend_nxt;
      done_r <= done_nxt;
      start_r <= start_nxt;
      chan_r <= chan_nxt;
    end
  end

  assign meas_start = start_r;
  assign meas_remote = chan_r;

  ////////////////////////////////////////////////////////////////////////////
  // result registers, read lock and limit flags

  logic [12:0] loc_res_nxt, rem_res_nxt, corr;
  logic loc_lock_r, loc_lock_nxt, rem_lock_r, rem_lock_nxt;
  logic [2:0] loc_flags_r, loc_flags_nxt, rem_flags_r, rem_flags_nxt;
  logic alert_n_r, alert_n_nxt;

  assign corr = trf_apply_offset(store_val, now_remote ? rem_ofs_r : loc_ofs_r); // RQ14

  always_comb
  begin
    loc_res_nxt = loc_res_r;
    rem_res_nxt = rem_res_r;
    loc_lock_nxt = loc_lock_r;
    rem_lock_nxt = rem_lock_r;
    loc_flags_nxt = loc_flags_r;
    rem_flags_nxt = rem_flags_r;
    // fraction read locks, integer read unlocks; integer alone leaves it open
    if (reg_rd && reg_addr == `TRF_ADDR_LOC_FRAC)
      loc_lock_nxt = 1'b1; // RQ16
    if (reg_rd && reg_addr == `TRF_ADDR_LOC_INT)
      loc_lock_nxt = 1'b0; // RQ16
    if (reg_rd && reg_addr == `TRF_ADDR_REM_FRAC)
      rem_lock_nxt = 1'b1; // RQ16
    if (reg_rd && reg_addr == `TRF_ADDR_REM_INT)
      rem_lock_nxt = 1'b0; // RQ16
    // flags follow every stored result; results only while unlocked
    if (store && !now_remote)
    begin
      loc_flags_nxt = trf_limits(corr, loc_high_r, loc_low_r, loc_ovt_r); // RQ12
      if (!loc_lock_r)
        loc_res_nxt = corr; // RQ16
    end
    if (store && now_remote)
    begin
      rem_flags_nxt = trf_limits(corr, rem_high_r, rem_low_r, rem_ovt_r); // RQ12
      if (!rem_lock_r)
        rem_res_nxt = corr; // RQ16
    end
    alert_n_nxt = !(|loc_flags_nxt[2:1] || |rem_flags_nxt[2:1]); // RQ12
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      loc_res_r <= {`TRF_RST_RESULT, 5'h00}; // RQ11
      rem_res_r <= {`TRF_RST_RESULT, 5'h00}; // RQ11
      loc_lock_r <= 1'b0;
      rem_lock_r <= 1'b0;
      loc_flags_r <= 3'h0;
      rem_flags_r <= 3'h0;
      alert_n_r <= 1'b1;
    end
    else if (ce)
    begin
      loc_res_r <= loc_res_nxt;
      rem_res_r <= rem_res_nxt;
      loc_lock_r <= loc_lock_nxt;
      rem_lock_r <= rem_lock_nxt;
      loc_flags_r <= loc_flags_nxt;
      rem_flags_r <= rem_flags_nxt;
      alert_n_r <= alert_n_nxt;
    end
  end

  assign loc_high_flag = loc_flags_r[2];
  assign loc_low_flag = loc_flags_r[1];
  assign loc_overtemp_flag = loc_flags_r[0];
  assign rem_high_flag = rem_flags_r[2];
  assign rem_low_flag = rem_flags_r[1];
  assign rem_overtemp_flag = rem_flags_r[0];
  assign alert_n = alert_n_r;

endmodule

// ---- test/trf_result_path_assertions.sv ----
// port-level checker for the temperature result path
`timescale 1ns/1ps
module trf_result_path_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic meas_valid,
  input wire logic meas_start,
  input wire logic meas_remote,
  input wire logic loc_high_flag,
  input wire logic loc_low_flag,
  input wire logic rem_high_flag,
  input wire logic rem_low_flag,
  input wire logic alert_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // alert is the overtemp-free or of the limit flags
  alert_follow_a: assert property (alert_n == !(loc_high_flag || loc_low_flag
    || rem_high_flag || rem_low_flag)) else $error("alert level disagrees with flags");
  // a frozen clock enable legally holds the pulse, so only running cycles count
  start_pulse_a: assert property (meas_start && ce |=> !meas_start)
    else $error("conversion request longer than one cycle");
  reset_clear_a: assert property (disable iff (1'b0) rst && ce |=> reg_rdata == 8'h00
    && alert_n && !meas_start) else $error("reset state wrong");
  unmapped_zero_a: assert property (ce && reg_rd && reg_addr >= 8'h50 |=>
    reg_rdata == 8'h00) else $error("unmapped read not zero");
  frac_upper_a: assert property (ce && reg_rd && (reg_addr == 8'h40 || reg_addr == 8'h42)
    |=> reg_rdata[7:5] == 3'h0) else $error("fraction upper bits set");
  rdata_hold_a: assert property (!(ce && reg_rd) |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  // a request never shares the cycle where the slot switches channel
  slot_gap_a: assert property ($changed(meas_remote) |-> !meas_start)
    else $error("request on slot change");
  flag_cause_a: assert property ($changed({loc_high_flag, loc_low_flag, rem_high_flag,
    rem_low_flag}) |-> $past(meas_valid)) else $error("flag moved without a sample");
  ce_freeze_a: assert property (!ce |=> $stable(reg_rdata) && $stable(meas_start)
    && $stable(alert_n)) else $error("state moved while disabled");

  cover property (meas_start && meas_remote);
  cover property (!alert_n);
  cover property (ce && reg_rd && reg_addr == 8'h40);
endmodule

// ---- test/test_trf_result_path.sv ----
// self-checking bench for the temperature result path
`timescale 1ns/1ps
module test_trf_result_path;
  typedef struct packed {logic [7:0] a; logic w; logic [7:0] d; logic [7:0] e;} trf_row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic rate_fast = 1'b1;
  logic meas_valid = 1'b0;
  logic [12:0] meas_data = 13'h0000;
  logic [7:0] reg_rdata;
  logic meas_start, meas_remote, alert_n;
  logic loc_high_flag, loc_low_flag, loc_overtemp_flag;
  logic rem_high_flag, rem_low_flag, rem_overtemp_flag;
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;
  logic req_seen = 1'b0;
  logic req_chan = 1'b0;
  // reset reads, a refused write, then the settings later cases rely on
  trf_row_t rows [0:17] = '{
    '{8'h0b, 1'b0, 8'h00, 8'h8b}, '{8'h0c, 1'b0, 8'h00, 8'h54}, '{8'h0d, 1'b0, 8'h00, 8'h95},
    '{8'h0e, 1'b0, 8'h00, 8'h8b}, '{8'h0f, 1'b0, 8'h00, 8'h54}, '{8'h10, 1'b0, 8'h00, 8'h95},
    '{8'h16, 1'b0, 8'h00, 8'h00}, '{8'h17, 1'b0, 8'h00, 8'h00}, '{8'h40, 1'b0, 8'h00, 8'h00},
    '{8'h41, 1'b0, 8'h00, 8'h00}, '{8'h42, 1'b0, 8'h00, 8'h00}, '{8'h43, 1'b0, 8'h00, 8'h00},
    '{8'h55, 1'b0, 8'h00, 8'h00}, '{8'h43, 1'b1, 8'hff, 8'h00}, '{8'h0b, 1'b1, 8'h55, 8'h55},
    '{8'h16, 1'b1, 8'h08, 8'h08}, '{8'h0c, 1'b1, 8'h54, 8'h54}, '{8'h0d, 1'b1, 8'h55, 8'h55}};

  trf_result_path #(.LOCAL_CYC(400), .REMOTE_AVG_CYC(800), .REMOTE_RAW_CYC(200)) u_dut (
    .clk, .rst, .ce, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .rate_fast,
    .meas_valid, .meas_data, .meas_start, .meas_remote, .loc_high_flag, .loc_low_flag,
    .loc_overtemp_flag, .rem_high_flag, .rem_low_flag, .rem_overtemp_flag, .alert_n);

  ////////////////////////////////////////////////////////////////////////////////////////////////
  always #20 clk = ~clk;
  // hang guard, well above the longest expected run; also notes each request,
  // since a read between samples would otherwise miss the one-cycle pulse
  always @(posedge clk)
  begin
    cyc++;
    if (meas_start === 1'b1)
    begin
      req_seen = 1'b1;
      req_chan = meas_remote;
    end
    if (cyc == 30000)
    begin
      n_fail++;
      stop_test;
    end
  end

  task automatic stop_test;
    if (n_fail == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk);
    #1 reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    #1 reg_rd = 1'b1;
    reg_addr = a;
    @(posedge clk);
    #1 reg_rd = 1'b0;
    chk(reg_rdata, e);
  endtask

  // waits for a request of the wanted channel, then answers one cycle later
  task automatic sample(input logic rem, input logic [12:0] d);
    int k;
    k = 0;
    while (!(req_seen === 1'b1 && req_chan === rem) && k < 2000)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    chk({7'h00, req_seen}, 8'h01);
    chk({7'h00, req_chan}, {7'h00, rem});
    req_seen = 1'b0;
    @(posedge clk);
    #1 meas_valid = 1'b1;
    meas_data = d;
    @(posedge clk);
    #1 meas_valid = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    for (int i = 0; i < 18; i++)
    begin
      if (rows[i].w)
        wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    // cycling mode reaches the remote channel too
    sample(1'b1, {8'h60, 5'h02});
    chk({5'h00, rem_high_flag, rem_low_flag, rem_overtemp_flag}, 8'h00);
    rd(8'h42, 8'h02);
    rd(8'h43, 8'h60);
    wr(8'h02, 8'h00);
    // +1 degree offset lands exactly on the high limit
    sample(1'b0, {8'h54, 5'h1c});
    chk({7'h00, loc_high_flag}, 8'h01);
    chk({7'h00, alert_n}, 8'h00);
    chk({7'h00, loc_overtemp_flag}, 8'h01);
    rd(8'h40, 8'h1c);
    rd(8'h41, 8'h55);
    // fraction read freezes the pair, flags still follow
    rd(8'h40, 8'h1c);
    sample(1'b0, {8'h40, 5'h03});
    chk({7'h00, loc_low_flag}, 8'h01);
    chk({7'h00, loc_high_flag}, 8'h00);
    chk({7'h00, loc_overtemp_flag}, 8'h00);
    rd(8'h41, 8'h55);
    sample(1'b0, {8'h40, 5'h03});
    rd(8'h41, 8'h41);
    // slow rate: nothing stored until the sixteenth sample
    rate_fast = 1'b0;
    for (int i = 0; i < 15; i++)
      sample(1'b0, i[0] ? 13'h0c00 : 13'h0c04);
    rd(8'h41, 8'h41);
    sample(1'b0, 13'h0c00);
    rd(8'h40, 8'h02);
    rd(8'h41, 8'h61);
    wr(8'h01, 8'h03);
    sample(1'b0, {8'h50, 5'h00});
    rd(8'h41, 8'h51);
    // most negative offset clamps a cold reading at the bottom
    wr(8'h16, 8'h80);
    sample(1'b0, {8'h05, 5'h00});
    rd(8'h41, 8'h00);
    wr(8'h02, 8'h10);
    sample(1'b1, {8'h70, 5'h00});
    rd(8'h43, 8'h70);
    // clock enable low holds everything, then a second reset
    ce = 1'b0;
    repeat (3) @(posedge clk);
    #1 ce = 1'b1;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    // the clamped local reading had raised the low flag before this reset
    chk({7'h00, alert_n}, 8'h01);
    chk({5'h00, loc_high_flag, loc_low_flag, loc_overtemp_flag}, 8'h00);
    rd(8'h43, 8'h00);
    rd(8'h0b, 8'h8b);
    rd(8'h16, 8'h00);
    stop_test;
  end
endmodule

bind trf_result_path trf_result_path_chk u_chk (.clk, .rst, .ce, .reg_addr, .reg_rd,
  .reg_rdata, .meas_valid, .meas_start, .meas_remote, .loc_high_flag, .loc_low_flag,
  .rem_high_flag, .rem_low_flag, .alert_n);
